// ---- so_params.svh ----
/*
  offsets, field positions, reset values and timing counts of the
  system options and periodic wakeup block.
  assumes a 32-bit AXI4-Lite register bus, one register per word.
*/
`ifndef SO_PARAMS_SVH
`define SO_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SO_OFS_OPTIONS  8'h00
`define SO_OFS_CLKOUT   8'h04
`define SO_OFS_ID_HIGH  8'h08
`define SO_OFS_ID_LOW   8'h0C
`define SO_OFS_WAKEUP   8'h10
// ----------------------------------------
// field positions
// ----------------------------------------
`define SO_OPT_WDOG_EN  7
`define SO_OPT_WDOG_LT  6
`define SO_OPT_STOP_EN  5
`define SO_CLK_PIN_EN   4
`define SO_WK_FLAG      7
`define SO_WK_ACK       6
`define SO_WK_CLKSEL    5
`define SO_WK_IE        4
// ----------------------------------------
// reset values
// ----------------------------------------
`define SO_OPT_RESET    8'hC0
`define SO_WK_RESET     8'h00
// ----------------------------------------
// wakeup delays: internal in ms, external in clock divisions
// ----------------------------------------
`define SO_INT_MS_1     16'd8
`define SO_INT_MS_2     16'd32
`define SO_INT_MS_3     16'd64
`define SO_INT_MS_4     16'd128
`define SO_INT_MS_5     16'd256
`define SO_INT_MS_6     16'd512
`define SO_INT_MS_7     16'd1024
`define SO_EXT_DIV_1    16'd256
`define SO_EXT_DIV_2    16'd1024
`define SO_EXT_DIV_3    16'd2048
`define SO_EXT_DIV_4    16'd4096
`define SO_EXT_DIV_5    16'd8192
`define SO_EXT_DIV_6    16'd16384
`define SO_EXT_DIV_7    16'd32768
`define SO_OSC_MS_TICK  16'd1
`endif

// ---- so_pkg.sv ----
/*
  types of the system options and periodic wakeup block.
  assumes nothing from so_params.svh; widths and response codes are set here.
*/
package so_pkg;
  // ----------------------------------------
  // bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } so_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } so_axi_rsp_t;
  typedef enum logic [1:0] {
    SO_RESP_OKAY   = 2'b00,
    SO_RESP_SLVERR = 2'b10
  } so_resp_t;
endpackage

// ---- so_sysopt.sv ----
/*
  system options, clock output divider, part identification and
  periodic wakeup timer behind an AXI4-Lite slave.
  assumes one bus clock; the 1 kHz oscillator and the external
  clock arrive as asynchronous levels and are synchronised here.
*/
// Our own choices: the register addresses and register access over AXI4-Lite.
// What this block does
// - options register honours only first write after reset
// - options bits 3 and 2 read zero
// - watchdog enable bit 7 resets to one
// - watchdog timeout bit 6 resets long
// - stop disabled forces illegal opcode reset
// - pin enable bit 4 routes divided clock
// - output clock is bus clock over 2N
// - zero divider with enable drives pin low
// - twelve-bit part identification, read only
// - identification high bits 7:4 reserved
// - wakeup flag bit 7 set on timeout
// - acknowledge bit 6 clears flag, reads zero
// - clock select bit 5 picks timer source
// - interrupt enable bit 4 gates request
// - delay code zero disables the timer
// - internal source gives 8 ms to 1.024 s
// - external source divides by 256 to 32768
// - wakeup register resets zero, bit 3 zero
`timescale 1ns/100ps
`include "so_params.svh"
module so_sysopt
  import so_pkg::*;
#(
  parameter logic [11:0] PART_ID = 12'h5A3  // value is arbitrary
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // register bus
  input  wire so_axi_req_t axi_req,
  output so_axi_rsp_t      axi_rsp,
  // wakeup clock sources, asynchronous
  input  wire logic        osc_1khz,
  input  wire logic        ext_clock,
  // cpu side
  input  wire logic        stop_exec,
  output logic             illegal_opcode_reset,
  output logic             watchdog_enable,
  output logic             watchdog_long_timeout,
  output logic             stop_mode_enable,
  output logic             wakeup_irq,
  // clock output port pin
  output logic             clock_output_port_pin,
  output logic             clock_output_port_oe
);

  // an all-zero code would be indistinguishable from an absent register
  if (PART_ID == 12'h000) begin : g_bad_id
    $error("part id must be nonzero");
  end

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  function automatic logic [15:0] wake_limit(
    input logic       ext_sel,
    input logic [2:0] code
  );
    logic [15:0] n;
    n = 16'd1;
    unique case (code)
      3'd1: n = ext_sel ? `SO_EXT_DIV_1 : `SO_INT_MS_1;
      3'd2: n = ext_sel ? `SO_EXT_DIV_2 : `SO_INT_MS_2;
      3'd3: n = ext_sel ? `SO_EXT_DIV_3 : `SO_INT_MS_3;
      3'd4: n = ext_sel ? `SO_EXT_DIV_4 : `SO_INT_MS_4;
      3'd5: n = ext_sel ? `SO_EXT_DIV_5 : `SO_INT_MS_5;
      3'd6: n = ext_sel ? `SO_EXT_DIV_6 : `SO_INT_MS_6;
      3'd7: n = ext_sel ? `SO_EXT_DIV_7 : `SO_INT_MS_7;
      3'd0: n = 16'd1;
    endcase
    if (!ext_sel) begin
      n = 16'(n * `SO_OSC_MS_TICK);
    end
    return 16'(n - 16'd1);
  endfunction

  function automatic logic is_reg(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return addr == ofs;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  logic [7:0]  opt_q;
  logic        opt_locked_q;
  logic        pin_en_q;
  logic [2:0]  div_q;
  logic [2:0]  div_cnt_q;
  logic        clk_out_q;
  logic        clk_oe_q;

  logic        wk_flag_q;
  logic        wk_clksel_q;
  logic        wk_ie_q;
  logic [2:0]  wk_code_q;
  logic [15:0] wk_cnt_q;
  logic        irq_q;
  logic        ilop_q;

  logic [2:0]  osc_sync_q;
  logic [2:0]  ext_sync_q;

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  wire aw_hs    = axi_req.awvalid & awready_q;
  wire w_hs     = axi_req.wvalid & wready_q;
  wire do_write = ~awready_q & ~wready_q & ~bvalid_q;
  wire b_hs     = bvalid_q & axi_req.bready;
  wire ar_hs    = axi_req.arvalid & arready_q;
  wire r_hs     = rvalid_q & axi_req.rready;
  wire lane0    = wstrb_q[0];

  wire wr_opt   = do_write & lane0 & is_reg(awaddr_q, `SO_OFS_OPTIONS);
  wire wr_clk   = do_write & lane0 & is_reg(awaddr_q, `SO_OFS_CLKOUT);
  wire wr_wk    = do_write & lane0 & is_reg(awaddr_q, `SO_OFS_WAKEUP);
  wire [7:0] wb = wdata_q[7:0];

  wire wr_hit =
    is_reg(awaddr_q, `SO_OFS_OPTIONS) | is_reg(awaddr_q, `SO_OFS_CLKOUT) |
    is_reg(awaddr_q, `SO_OFS_ID_HIGH) | is_reg(awaddr_q, `SO_OFS_ID_LOW) |
    is_reg(awaddr_q, `SO_OFS_WAKEUP);

  // ----------------------------------------
  // read selection
  // ----------------------------------------
  wire [7:0] ra = axi_req.araddr;
  wire [7:0] rd_opt = {opt_q[7:5], 1'b0, 2'b00, opt_q[1:0]};
  wire [7:0] rd_clk = {3'b000, pin_en_q, 1'b0, div_q};
  wire [7:0] rd_idh = {4'h0, PART_ID[11:8]};
  wire [7:0] rd_idl = PART_ID[7:0];
  wire [7:0] rd_wk  =
    {wk_flag_q, 1'b0, wk_clksel_q, wk_ie_q, 1'b0, wk_code_q};
  wire       rd_hit =
    is_reg(ra, `SO_OFS_OPTIONS) | is_reg(ra, `SO_OFS_CLKOUT) |
    is_reg(ra, `SO_OFS_ID_HIGH) | is_reg(ra, `SO_OFS_ID_LOW) |
    is_reg(ra, `SO_OFS_WAKEUP);
  wire [7:0] rd_byte =
    is_reg(ra, `SO_OFS_OPTIONS) ? rd_opt :
    is_reg(ra, `SO_OFS_CLKOUT)  ? rd_clk :
    is_reg(ra, `SO_OFS_ID_HIGH) ? rd_idh :
    is_reg(ra, `SO_OFS_ID_LOW)  ? rd_idl :
    is_reg(ra, `SO_OFS_WAKEUP)  ? rd_wk  : 8'h00;

  // ----------------------------------------
  // axi write path
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        awaddr_q  <= axi_req.awaddr;
      end else if (do_write) begin
        awready_q <= 1'b1;
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        wdata_q  <= axi_req.wdata;
        wstrb_q  <= axi_req.wstrb;
      end else if (do_write) begin
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= SO_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? SO_RESP_OKAY : SO_RESP_SLVERR;
    end else if (b_hs) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // axi read path
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= SO_RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_byte};
      rresp_q   <= rd_hit ? SO_RESP_OKAY : SO_RESP_SLVERR;
    end else if (r_hs) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign axi_rsp = '{
    awready: awready_q,
    wready:  wready_q,
    bvalid:  bvalid_q,
    bresp:   bresp_q,
    arready: arready_q,
    rvalid:  rvalid_q,
    rdata:   rdata_q,
    rresp:   rresp_q
  };

  // ----------------------------------------
  // system options, write once
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      opt_q        <= `SO_OPT_RESET;
      opt_locked_q <= 1'b0;
    end else if (wr_opt && !opt_locked_q) begin
      opt_q        <= wb & 8'hE3;
      opt_locked_q <= 1'b1;
    end
  end

  assign watchdog_enable       = opt_q[`SO_OPT_WDOG_EN];
  assign watchdog_long_timeout = opt_q[`SO_OPT_WDOG_LT];
  assign stop_mode_enable      = opt_q[`SO_OPT_STOP_EN];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ilop_q <= 1'b0;
    end else begin
      ilop_q <= stop_exec & ~opt_q[`SO_OPT_STOP_EN];
    end
  end

  assign illegal_opcode_reset = ilop_q;

  // ----------------------------------------
  // clock output divider
  // ----------------------------------------
  wire       div_zero = div_q == 3'd0;
  wire       div_end  = div_cnt_q == 3'(div_q - 3'd1);
  wire [2:0] div_inc  = 3'(div_cnt_q + 3'd1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_en_q <= 1'b0;
      div_q    <= 3'd0;
    end else if (wr_clk) begin
      pin_en_q <= wb[`SO_CLK_PIN_EN];
      div_q    <= wb[2:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_cnt_q <= 3'd0;
      clk_out_q <= 1'b0;
      clk_oe_q  <= 1'b0;
    end else begin
      clk_oe_q <= pin_en_q;
      if (!pin_en_q || div_zero || wr_clk) begin
        div_cnt_q <= 3'd0;
        clk_out_q <= 1'b0;
      end else if (div_end) begin
        div_cnt_q <= 3'd0;
        clk_out_q <= ~clk_out_q;
      end else begin
        div_cnt_q <= div_inc;
      end
    end
  end

  assign clock_output_port_pin = clk_out_q;
  assign clock_output_port_oe  = clk_oe_q;

  // ----------------------------------------
  // wakeup source synchronisers
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      osc_sync_q <= 3'b000;
      ext_sync_q <= 3'b000;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], osc_1khz};
      ext_sync_q <= {ext_sync_q[1:0], ext_clock};
    end
  end

  wire osc_rise = osc_sync_q[1] & ~osc_sync_q[2];
  wire ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
  wire wk_tick  = wk_clksel_q ? ext_rise : osc_rise;

  // ----------------------------------------
  // periodic wakeup timer
  // ----------------------------------------
  wire [15:0] wk_lim  = wake_limit(wk_clksel_q, wk_code_q);
  wire        wk_off  = wk_code_q == 3'd0;
  wire        wk_hit  = wk_tick & ~wk_off & (wk_cnt_q == wk_lim);
  wire        wk_ack  = wr_wk & wb[`SO_WK_ACK];
  wire        wk_cfg  = wr_wk &&
    ({wb[`SO_WK_CLKSEL], wb[2:0]} != {wk_clksel_q, wk_code_q});

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wk_clksel_q <= 1'(`SO_WK_RESET >> `SO_WK_CLKSEL);
      wk_ie_q     <= 1'b0;
      wk_code_q   <= 3'd0;
    end else if (wr_wk) begin
      wk_clksel_q <= wb[`SO_WK_CLKSEL];
      wk_ie_q     <= wb[`SO_WK_IE];
      wk_code_q   <= wb[2:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wk_cnt_q <= 16'h0000;
    end else if (wk_off || wk_cfg) begin
      wk_cnt_q <= 16'h0000;
    end else if (wk_hit) begin
      wk_cnt_q <= 16'h0000;
    end else if (wk_tick) begin
      wk_cnt_q <= 16'(wk_cnt_q + 16'h0001);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wk_flag_q <= 1'b0;
    end else if (wk_hit) begin
      wk_flag_q <= 1'b1;
    end else if (wk_ack) begin
      wk_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= wk_flag_q & wk_ie_q;
    end
  end

  assign wakeup_irq = irq_q;

endmodule

// ---- so_sysopt_chk.sv ----
/*
  port assertions of so_sysopt.
  assumes a bind onto so_sysopt, one clock domain.
*/
`timescale 1ns/100ps
module so_sysopt_chk
  import so_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // register bus
  input wire so_axi_req_t axi_req,
  input wire so_axi_rsp_t axi_rsp,
  // cpu side and pin
  input wire logic        stop_exec,
  input wire logic        illegal_opcode_reset,
  input wire logic        watchdog_enable,
  input wire logic        watchdog_long_timeout,
  input wire logic        stop_mode_enable,
  input wire logic        clock_output_port_pin,
  input wire logic        clock_output_port_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // tracks the options write that used the single chance
  // ----------------------------------------
  logic [7:0] wa_q;
  logic       ws_q;
  logic       used_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wa_q   <= 8'h00;
      ws_q   <= 1'b0;
      used_q <= 1'b0;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) wa_q <= axi_req.awaddr;
      if (axi_req.wvalid && axi_rsp.wready) ws_q <= axi_req.wstrb[0];
      if (axi_rsp.bvalid && axi_req.bready && wa_q == 8'h00 && ws_q) used_q <= 1'b1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_opts_frozen: assert property ($past(used_q, 2) |->
    $stable({watchdog_enable, watchdog_long_timeout, stop_mode_enable}))
    else $error("options changed after the first write");
  chk_stop_trap: assert property (stop_exec && !stop_mode_enable |=>
    illegal_opcode_reset) else $error("stop while disabled gave no trap");
  chk_trap_cause: assert property (illegal_opcode_reset |->
    $past(stop_exec) && !$past(stop_mode_enable)) else $error("trap without cause");
  chk_pin_idle: assert property (!clock_output_port_oe &&
    !$past(clock_output_port_oe) |-> !clock_output_port_pin) else $error("pin active undriven");
  chk_b_timing: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
    axi_rsp.wready && !axi_rsp.bvalid |-> ##2 axi_rsp.bvalid) else $error("late write answer");
  chk_b_holds: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped");
  chk_r_timing: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("late read answer");
  chk_r_holds: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read answer dropped");
  chk_r_upper: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
endmodule

bind so_sysopt so_sysopt_chk u_chk (
  .clock                 (clock),
  .nrst                  (nrst),
  .axi_req               (axi_req),
  .axi_rsp               (axi_rsp),
  .stop_exec             (stop_exec),
  .illegal_opcode_reset  (illegal_opcode_reset),
  .watchdog_enable       (watchdog_enable),
  .watchdog_long_timeout (watchdog_long_timeout),
  .stop_mode_enable      (stop_mode_enable),
  .clock_output_port_pin (clock_output_port_pin),
  .clock_output_port_oe  (clock_output_port_oe)
);

// ---- tb.sv ----
/*
  self-checking bench of so_sysopt, registers over AXI4-Lite.
  assumes fast stand-ins for the oscillator and the external clock.
*/
`timescale 1ns/100ps
`include "so_params.svh"
module tb
  import so_pkg::*;
;
  localparam logic [11:0] ID = 12'ha5c;  // value is arbitrary
  logic        clock     = 1'b0;
  logic        nrst      = 1'b0;
  logic        osc_1khz  = 1'b0;
  logic        ext_clock = 1'b0;
  logic        stop_exec = 1'b0;
  so_axi_req_t req       = '0;
  so_axi_rsp_t rsp;
  logic        ilop, wd_en, wd_lt, stop_en, irq, pin, oe;
  logic [31:0] rd, v;
  logic [1:0]  rs;
  int          err_total, total_checks, cyc;

  always #2 clock = ~clock;
  // oscillator stand-in has period 4, external clock period 6
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 1) osc_1khz <= ~osc_1khz;
    if (cyc % 3 == 2) ext_clock <= ~ext_clock;
    if (cyc == 90000) begin
      err_total++;
      report_and_stop();
    end
  end

  so_sysopt #(.PART_ID(ID)) dut (
    .clock(clock), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
    .osc_1khz(osc_1khz), .ext_clock(ext_clock), .stop_exec(stop_exec),
    .illegal_opcode_reset(ilop), .watchdog_enable(wd_en),
    .watchdog_long_timeout(wd_lt), .stop_mode_enable(stop_en), .wakeup_irq(irq),
    .clock_output_port_pin(pin), .clock_output_port_oe(oe));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clock);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      rs = rsp.bresp;
    end while (!(req.bready && rsp.bvalid));
    req.bready <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    @(posedge clock);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clock);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      rd = rsp.rdata;
      rs = rsp.rresp;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    chk(n, e, rd & m);
  endtask
  task automatic trap(input logic e);
    @(posedge clock) stop_exec <= 1'b1;
    @(posedge clock) stop_exec <= 1'b0;
    #1 chk("trap", 32'(e), 32'(ilop));
  endtask
  task automatic half(input int k);
    int n;
    n = 0;
    if (k == 0) begin
      repeat (16) begin
        @(posedge clock);
        if (pin !== 1'b0) n++;
      end
    end else begin
      while (pin !== 1'b0) @(posedge clock);
      while (pin !== 1'b1) @(posedge clock);
      while (pin === 1'b1) begin
        n++;
        @(posedge clock);
      end
    end
    chk("half_period", k, n);
  endtask
  task automatic wait_irq();
    repeat (2) @(posedge clock);
    while (irq !== 1'b1) @(posedge clock);
  endtask
  function automatic int edges(int s, int c);
    if (c == 1) return s ? 256 : 8;
    return (s ? 512 : 16) << (c - 1);
  endfunction
  task automatic wake(input int s, input int c);
    logic [31:0] w;
    int          t0;
    w = 32'h0000_0050 | 32'(s) << 5 | 32'(c);
    wr(`SO_OFS_WAKEUP, w, 4'h1);
    wait_irq();
    t0 = cyc;
    rchk("wakeup", `SO_OFS_WAKEUP, (w & 32'h0000_003f) | 32'h0000_0080, 32'h0000_00ff);
    wr(`SO_OFS_WAKEUP, w, 4'h1);
    repeat (2) @(posedge clock);
    chk("irq_ack", 0, 32'(irq));
    wait_irq();
    chk("interval", edges(s, c) * (s ? 6 : 4), cyc - t0);
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'he780_452d));
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    rchk("options", `SO_OFS_OPTIONS, 32'h0000_00c0, 32'h0000_00ff);
    chk("opt_ports", 32'h0000_0006, 32'({wd_en, wd_lt, stop_en}));
    rchk("wakeup", `SO_OFS_WAKEUP, 32'h0000_0000, 32'h0000_00ff);
    rchk("id_high", `SO_OFS_ID_HIGH, 32'(ID[11:8]), 32'h0000_000f);
    rchk("id_low", `SO_OFS_ID_LOW, 32'(ID[7:0]), 32'h0000_00ff);
    trap(1'b1);
    v = $urandom();
    v[5] = 1'b1;
    wr(`SO_OFS_OPTIONS, v, 4'h1);
    rchk("options", `SO_OFS_OPTIONS, v & 32'h0000_00e3, 32'h0000_00ff);
    chk("opt_ports", 32'(v[7:5]), 32'({wd_en, wd_lt, stop_en}));
    trap(1'b0);
    wr(`SO_OFS_OPTIONS, ~v, 4'hf);
    rchk("options", `SO_OFS_OPTIONS, v & 32'h0000_00e3, 32'h0000_00ff);
    wr(`SO_OFS_ID_HIGH, 32'hffff_ffff, 4'hf);
    wr(`SO_OFS_ID_LOW, 32'hffff_ffff, 4'hf);
    rchk("id_high", `SO_OFS_ID_HIGH, 32'(ID[11:8]), 32'h0000_000f);
    rchk("id_low", `SO_OFS_ID_LOW, 32'(ID[7:0]), 32'h0000_00ff);
    rchk("unmapped_data", 8'h14, 32'h0000_0000, 32'hffff_ffff);
    chk("unmapped_rresp", 32'(SO_RESP_SLVERR), 32'(rs));
    wr(8'h14, 32'h0000_00ff, 4'hf);
    chk("unmapped_bresp", 32'(SO_RESP_SLVERR), 32'(rs));
    for (int k = 1; k < 8; k++) begin
      v = $urandom();
      v[4:0] = 5'h10 | 5'(k);
      wr(`SO_OFS_CLKOUT, v, 4'h1);
      rchk("clkout", `SO_OFS_CLKOUT, v & 32'h0000_0017, 32'h0000_00ff);
      half(k);
      chk("pin_oe", 1, 32'(oe));
    end
    wr(`SO_OFS_CLKOUT, 32'h0000_0010, 4'h1);
    half(0);
    chk("pin_oe", 1, 32'(oe));
    wr(`SO_OFS_CLKOUT, 32'h0000_0017, 4'h0);
    wr(`SO_OFS_CLKOUT, 32'h0000_0000, 4'h1);
    repeat (3) @(posedge clock);
    chk("pin_oe", 0, 32'({oe, pin}));
    rchk("clkout", `SO_OFS_CLKOUT, 32'h0000_0000, 32'h0000_00ff);
    for (int s = 0; s < 2; s++)
      for (int c = 1; c < 8; c++)
        if (s == 0 || c < 4) wake(s, c);
    wr(`SO_OFS_WAKEUP, 32'h0000_0041, 4'h1);
    repeat (100) @(posedge clock);
    chk("irq_masked", 0, 32'(irq));
    rchk("wakeup", `SO_OFS_WAKEUP, 32'h0000_0081, 32'h0000_00ff);
    wr(`SO_OFS_WAKEUP, 32'h0000_0040, 4'h1);
    repeat (100) @(posedge clock);
    rchk("wakeup", `SO_OFS_WAKEUP, 32'h0000_0000, 32'h0000_00ff);
    report_and_stop();
  end
endmodule
